// *** cbc_checker.sv ***
// Purpose: Port-level checks for the clock and boot control block
// Assumes: Sees only the top-level ports; attached by the bind below
// Notes:   Post-boot checks key off the rise of core_rst_n
`timescale 1ns/1ps
`include "cbc_map.svh"

module cbc_checker #(
  parameter logic [11:0] BOOT_FAST_CYC   = `CBC_BOOT_FAST,
  parameter logic [11:0] BOOT_NORMAL_CYC = `CBC_BOOT_NORMAL,
  parameter int          MEM_DEPTH       = 128
) (
  // Clock, reset and APB
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins, straps and controls
  input wire logic        slow_rc_pin, fast_boot_strap, core_rst_n, fast_rc_en,
  input wire logic        slow_rc_en, crystal_osc_en, wdt_en, port_a_pin_five_out,
  input wire logic [2:0]  calib_opt_strap, sys_clk_sel,
  input wire logic [10:0] pc_start_addr, pc_irq_addr,
  input wire logic [7:0]  fast_rc_trim
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        acc;
  logic        wr_mode;
  logic        wr_xtal;
  logic [31:0] wd_q;

  // Completed accesses; mode writes during boot are left out, boot settings win there
  assign acc     = psel & penable & pready;
  assign wr_mode = acc & pwrite & (paddr == `CBC_OFS_CLK_MODE) & core_rst_n;
  assign wr_xtal = acc & pwrite & (paddr == `CBC_OFS_XTAL_CTRL);

  // Write data of the previous cycle
  always_ff @(posedge pclk) begin
    wd_q <= pwdata;
  end

  ready_wait_a: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood too long");
  bad_addr_a: assert property (acc && paddr >= 12'h030 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  entry_word_a: assert property (pc_start_addr == 11'h001)
    else $error("wrong start address");
  irq_vector_a: assert property (pc_irq_addr == 11'h010)
    else $error("wrong interrupt vector");
  boot_hold_a: assert property (core_rst_n |=> core_rst_n)
    else $error("core reset dropped back");
  fast_opt_a: assert property ($rose(core_rst_n) && calib_opt_strap < 3'd5 |->
    fast_rc_en && slow_rc_en && !wdt_en && !port_a_pin_five_out
    && sys_clk_sel == calib_opt_strap) else $error("divided option state wrong");
  slow_opt_a: assert property ($rose(core_rst_n) && calib_opt_strap == 3'd5 |->
    !fast_rc_en && slow_rc_en && wdt_en && sys_clk_sel == 3'd6)
    else $error("slow option state wrong");
  calib_off_a: assert property ($rose(core_rst_n) && calib_opt_strap > 3'd5 |->
    wdt_en && sys_clk_sel == (fast_boot_strap ? 3'd5 : 3'd6))
    else $error("calibration off state wrong");
  osc_en_a: assert property (wr_mode |=> fast_rc_en == wd_q[4] && slow_rc_en == wd_q[2])
    else $error("rc enables not from mode bits");
  slow_mode_a: assert property (wr_mode && pwdata[7:0] == 8'hE4 |=> sys_clk_sel == 3'd6)
    else $error("slow mode not selected");
  xtal_en_a: assert property (wr_xtal |=> crystal_osc_en == wd_q[7])
    else $error("crystal enable not from bit 7");

  // Main scenarios
  cover property ($rose(core_rst_n) && calib_opt_strap == 3'd5);
  cover property (acc && pslverr);
  cover property (wr_mode);
endmodule

bind cbc_clock_boot_control cbc_checker #(
  .BOOT_FAST_CYC(BOOT_FAST_CYC), .BOOT_NORMAL_CYC(BOOT_NORMAL_CYC), .MEM_DEPTH(MEM_DEPTH)
) i_cbc_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .slow_rc_pin(slow_rc_pin), .fast_boot_strap(fast_boot_strap), .core_rst_n(core_rst_n),
  .fast_rc_en(fast_rc_en), .slow_rc_en(slow_rc_en), .crystal_osc_en(crystal_osc_en),
  .wdt_en(wdt_en), .port_a_pin_five_out(port_a_pin_five_out),
  .calib_opt_strap(calib_opt_strap), .sys_clk_sel(sys_clk_sel),
  .pc_start_addr(pc_start_addr), .pc_irq_addr(pc_irq_addr), .fast_rc_trim(fast_rc_trim)
);

// *** cbc_clock_boot_control.sv ***
// Purpose: Power-on boot delay, oscillator enables, clock select and data memory access
// Assumes: Slow RC arrives as a pin and is sampled on pclk; straps are static
// Notes:   APB slave answering in the first access cycle; all outputs registered
`timescale 1ns/1ps
`include "cbc_map.svh"

module cbc_clock_boot_control #(
  parameter logic [11:0] BOOT_FAST_CYC   = `CBC_BOOT_FAST,
  parameter logic [11:0] BOOT_NORMAL_CYC = `CBC_BOOT_NORMAL,
  parameter int          MEM_DEPTH       = 128
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pins and straps
  input  wire logic        slow_rc_pin,
  input  wire logic        fast_boot_strap,
  input  wire logic [2:0]  calib_opt_strap,
  // Core and clock tree controls
  output logic             core_rst_n,
  output logic [10:0]      pc_start_addr,
  output logic [10:0]      pc_irq_addr,
  output logic             fast_rc_en,
  output logic             slow_rc_en,
  output logic             crystal_osc_en,
  output logic [7:0]       fast_rc_trim,
  output logic [2:0]       sys_clk_sel,
  output logic             wdt_en,
  output logic             port_a_pin_five_out
);

  // Decode a clock mode byte; valid flag false for unknown codes
  function automatic logic [3:0] cbc_decode(input logic [7:0] mode);
    logic [3:0] res;
    res = {1'b0, cbc_pkg::CBC_SEL_SLOW};
    unique case (mode)
      `CBC_CLKMD_FRC2:  res = {1'b1, cbc_pkg::CBC_SEL_FRC2};
      `CBC_CLKMD_FRC4:  res = {1'b1, cbc_pkg::CBC_SEL_FRC4};
      `CBC_CLKMD_FRC8:  res = {1'b1, cbc_pkg::CBC_SEL_FRC8};
      `CBC_CLKMD_FRC16: res = {1'b1, cbc_pkg::CBC_SEL_FRC16};
      `CBC_CLKMD_FRC32: res = {1'b1, cbc_pkg::CBC_SEL_FRC32};
      `CBC_CLKMD_SLOW:  res = {1'b1, cbc_pkg::CBC_SEL_SLOW};
      default:          res = {1'b0, cbc_pkg::CBC_SEL_SLOW};
    endcase
    return res;
  endfunction

  // Classify a program word address
  function automatic cbc_pkg::cbc_pm_class_t cbc_pm_class(input logic [10:0] a);
    cbc_pkg::cbc_pm_class_t c;
    c = cbc_pkg::CBC_PM_USER;
    if (a == `CBC_PM_SYS_LOW || a >= `CBC_PM_SYS_HIGH) begin
      c = cbc_pkg::CBC_PM_SYSTEM;
    end else if (a == `CBC_PM_ENTRY) begin
      c = cbc_pkg::CBC_PM_START;
    end else if (a == `CBC_PM_VECTOR) begin
      c = cbc_pkg::CBC_PM_IRQ;
    end
    return c;
  endfunction

  // Slow RC and strap synchronisers
  logic       src_s1_r;
  logic       src_s2_r;
  logic       src_d_r;
  logic       fb_s1_r;
  logic       fb_s2_r;
  logic [2:0] co_s1_r;
  logic [2:0] co_s2_r;

  // Two flops per pin, a third on slow RC for edge detect; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1_r <= 1'b0;
      src_s2_r <= 1'b0;
      src_d_r  <= 1'b0;
      fb_s1_r  <= 1'b0;
      fb_s2_r  <= 1'b0;
      co_s1_r  <= 3'h0;
      co_s2_r  <= 3'h0;
    end else begin
      src_s1_r <= slow_rc_pin;
      src_s2_r <= src_s1_r;
      src_d_r  <= src_s2_r;
      fb_s1_r  <= fast_boot_strap;
      fb_s2_r  <= fb_s1_r;
      co_s1_r  <= calib_opt_strap;
      co_s2_r  <= co_s1_r;
    end
  end

  // One-cycle tick per slow RC rising edge
  logic src_tick;
  assign src_tick = src_s2_r & ~src_d_r;

  // Boot sequencer state
  cbc_pkg::cbc_state_t st_r, st_nxt;
  logic [11:0] boot_cnt_r, boot_cnt_nxt;
  logic [1:0]  strap_cnt_r, strap_cnt_nxt;
  logic        fast_boot_r, fast_boot_nxt;
  logic [2:0]  calib_r, calib_nxt;
  logic        core_rst_n_r, core_rst_n_nxt;
  logic        apply_now;

  // Register file state
  logic [7:0]  clk_mode_r, clk_mode_nxt;
  logic [7:0]  xtal_r, xtal_nxt;
  logic [7:0]  trim_r, trim_nxt;
  logic        wdt_r, wdt_nxt;
  logic        pa5_out_r, pa5_out_nxt;
  logic [2:0]  sel_r, sel_nxt;
  logic [7:0]  sp_r, sp_nxt;
  logic [10:0] pmap_r, pmap_nxt;
  logic [6:0]  mptr_r, mptr_nxt;
  logic [2:0]  mbit_r, mbit_nxt;
  logic        pready_r, pready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pslverr_r, pslverr_nxt;

  // Data memory
  logic [7:0]  mem [0:MEM_DEPTH-1];
  logic        mem_we;
  logic [6:0]  mem_waddr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_at_ptr;
  logic [6:0]  ind_addr;
  logic [7:0]  mem_at_ind;

  assign mem_at_ptr = mem[mptr_r];
  assign ind_addr   = mem_at_ptr[6:0];
  assign mem_at_ind = mem[ind_addr];

  // Boot sequencer next state
  always_comb begin
    st_nxt         = st_r;
    boot_cnt_nxt   = boot_cnt_r;
    strap_cnt_nxt  = strap_cnt_r;
    fast_boot_nxt  = fast_boot_r;
    calib_nxt      = calib_r;
    core_rst_n_nxt = core_rst_n_r;
    apply_now      = 1'b0;
    unique case (st_r)
      cbc_pkg::CBC_ST_STRAP: begin
        // Straps settle through the synchronisers before capture
        strap_cnt_nxt = strap_cnt_r + 2'd1;
        if (strap_cnt_r == `CBC_STRAP_WAIT) begin
          fast_boot_nxt = fb_s2_r;
          calib_nxt     = co_s2_r;
          st_nxt        = cbc_pkg::CBC_ST_COUNT;
        end
      end
      cbc_pkg::CBC_ST_COUNT: begin
        if (src_tick) begin
          boot_cnt_nxt = boot_cnt_r + 12'd1;
          if (boot_cnt_r + 12'd1 >= (fast_boot_r ? BOOT_FAST_CYC : BOOT_NORMAL_CYC)) begin
            st_nxt = cbc_pkg::CBC_ST_APPLY;
          end
        end
      end
      cbc_pkg::CBC_ST_APPLY: begin
        apply_now      = 1'b1;
        core_rst_n_nxt = 1'b1;
        st_nxt         = cbc_pkg::CBC_ST_RUN;
      end
      cbc_pkg::CBC_ST_RUN: begin
        st_nxt = cbc_pkg::CBC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= cbc_pkg::CBC_ST_STRAP;
      boot_cnt_r   <= 12'h000;
      strap_cnt_r  <= 2'h0;
      fast_boot_r  <= 1'b0;
      calib_r      <= 3'h0;
      core_rst_n_r <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      boot_cnt_r   <= boot_cnt_nxt;
      strap_cnt_r  <= strap_cnt_nxt;
      fast_boot_r  <= fast_boot_nxt;
      calib_r      <= calib_nxt;
      core_rst_n_r <= core_rst_n_nxt;
    end
  end

  // APB decode and register next values
  logic        setup_ph;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_val;
  logic [3:0]  dec_w;
  logic [7:0]  wbyte;

  assign setup_ph = psel & ~penable;
  assign wr_done  = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign wbyte    = pwdata[7:0];
  assign dec_w    = cbc_decode(wbyte);

  always_comb begin
    clk_mode_nxt = clk_mode_r;
    xtal_nxt     = xtal_r;
    trim_nxt     = trim_r;
    wdt_nxt      = wdt_r;
    pa5_out_nxt  = pa5_out_r;
    sel_nxt      = sel_r;
    sp_nxt       = sp_r;
    pmap_nxt     = pmap_r;
    mptr_nxt     = mptr_r;
    mbit_nxt     = mbit_r;
    mem_we       = 1'b0;
    mem_waddr    = mptr_r;
    mem_wdata    = mem_at_ptr;
    hit          = 1'b1;
    rd_val       = 32'h0000_0000;
    // Read mux, sampled in the setup cycle
    unique case (paddr)
      `CBC_OFS_CLK_MODE:   rd_val = {24'h0, clk_mode_r};
      `CBC_OFS_XTAL_CTRL:  rd_val = {24'h0, xtal_r};
      `CBC_OFS_FRC_TRIM:   rd_val = {24'h0, trim_r};
      `CBC_OFS_SYS_CTRL:   rd_val = {30'h0, pa5_out_r, wdt_r};
      `CBC_OFS_STATUS:     rd_val = {24'h0, calib_r, sel_r, fast_boot_r, core_rst_n_r};
      `CBC_OFS_BOOT_COUNT: rd_val = {20'h0, boot_cnt_r};
      `CBC_OFS_STACK_PTR:  rd_val = {24'h0, sp_r};
      `CBC_OFS_PMAP_CHECK: rd_val = {13'h0, cbc_pm_class(pmap_r), 5'h0, pmap_r};
      `CBC_OFS_MEM_PTR:    rd_val = {25'h0, mptr_r};
      `CBC_OFS_MEM_DATA:   rd_val = {24'h0, mem_at_ptr};
      `CBC_OFS_MEM_BIT:    rd_val = {28'h0, mem_at_ptr[mbit_r], mbit_r};
      `CBC_OFS_MEM_IND:    rd_val = {24'h0, mem_at_ind};
      default: begin
        hit    = 1'b0;
        rd_val = 32'h0000_0000;
      end
    endcase
    // Software writes at the completing access edge
    if (wr_done) begin
      unique case (paddr)
        `CBC_OFS_CLK_MODE: begin
          clk_mode_nxt = wbyte;
          if (dec_w[3]) begin
            sel_nxt = dec_w[2:0];
          end
        end
        `CBC_OFS_XTAL_CTRL: xtal_nxt = wbyte;
        `CBC_OFS_FRC_TRIM: trim_nxt = wbyte;
        `CBC_OFS_SYS_CTRL: begin
          wdt_nxt     = pwdata[`CBC_BIT_WDT_EN];
          pa5_out_nxt = pwdata[`CBC_BIT_PA5_OUT];
        end
        `CBC_OFS_STACK_PTR: sp_nxt = wbyte;
        `CBC_OFS_PMAP_CHECK: pmap_nxt = pwdata[10:0];
        `CBC_OFS_MEM_PTR: mptr_nxt = pwdata[6:0];
        `CBC_OFS_MEM_DATA: begin
          mem_we    = 1'b1;
          mem_wdata = wbyte;
        end
        `CBC_OFS_MEM_BIT: begin
          mbit_nxt  = pwdata[2:0];
          mem_we    = 1'b1;
          mem_wdata = mem_at_ptr;
          mem_wdata[pwdata[2:0]] = pwdata[`CBC_BIT_MEM_VAL];
        end
        `CBC_OFS_MEM_IND: begin
          mem_we    = 1'b1;
          mem_waddr = ind_addr;
          mem_wdata = wbyte;
        end
        default: begin
          hit = hit;
        end
      endcase
    end
    // Post-boot settings win over software in the release cycle
    if (apply_now) begin
      clk_mode_nxt[`CBC_BIT_SRC_EN] = 1'b1;
      if (calib_r <= 3'd4) begin
        unique case (calib_r)
          3'd0:    clk_mode_nxt = `CBC_CLKMD_FRC2;
          3'd1:    clk_mode_nxt = `CBC_CLKMD_FRC4;
          3'd2:    clk_mode_nxt = `CBC_CLKMD_FRC8;
          3'd3:    clk_mode_nxt = `CBC_CLKMD_FRC16;
          default: clk_mode_nxt = `CBC_CLKMD_FRC32;
        endcase
        sel_nxt     = calib_r;
        wdt_nxt     = 1'b0;
        pa5_out_nxt = 1'b0;
      end else if (calib_r == 3'd5) begin
        clk_mode_nxt = `CBC_CLKMD_SLOW;
        sel_nxt      = cbc_pkg::CBC_SEL_SLOW;
        wdt_nxt      = 1'b1;
        pa5_out_nxt  = 1'b0;
      end else begin
        clk_mode_nxt = `CBC_RST_CLK_MODE;
        sel_nxt      = fast_boot_r ? cbc_pkg::CBC_SEL_FRC64 : cbc_pkg::CBC_SEL_SLOW;
        wdt_nxt      = 1'b1;
        pa5_out_nxt  = 1'b0;
      end
    end
  end

  // APB answer next values: no wait state, data caught at setup
  always_comb begin
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (setup_ph) begin
      pready_nxt  = 1'b1;
      prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
      pslverr_nxt = ~hit;
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_mode_r <= `CBC_RST_CLK_MODE;
      xtal_r     <= `CBC_RST_XTAL_CTRL;
      trim_r     <= `CBC_RST_FRC_TRIM;
      wdt_r      <= 1'b1;
      pa5_out_r  <= 1'b0;
      sel_r      <= cbc_pkg::CBC_SEL_SLOW;
      sp_r       <= 8'h00;
      pmap_r     <= 11'h000;
      mptr_r     <= 7'h00;
      mbit_r     <= 3'h0;
      pready_r   <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pslverr_r  <= 1'b0;
    end else begin
      clk_mode_r <= clk_mode_nxt;
      xtal_r     <= xtal_nxt;
      trim_r     <= trim_nxt;
      wdt_r      <= wdt_nxt;
      pa5_out_r  <= pa5_out_nxt;
      sel_r      <= sel_nxt;
      sp_r       <= sp_nxt;
      pmap_r     <= pmap_nxt;
      mptr_r     <= mptr_nxt;
      mbit_r     <= mbit_nxt;
      pready_r   <= pready_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // Memory has no reset; contents are undefined after power-up
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Fixed fetch addresses held in flops
  logic [10:0] pc_start_r;
  logic [10:0] pc_irq_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_start_r <= `CBC_PM_ENTRY;
      pc_irq_r   <= `CBC_PM_VECTOR;
    end else begin
      pc_start_r <= pc_start_r;
      pc_irq_r   <= pc_irq_r;
    end
  end

  // Outputs straight from flops
  assign pready              = pready_r;
  assign prdata              = prdata_r;
  assign pslverr             = pslverr_r;
  assign core_rst_n          = core_rst_n_r;
  assign pc_start_addr       = pc_start_r;
  assign pc_irq_addr         = pc_irq_r;
  assign fast_rc_en          = clk_mode_r[`CBC_BIT_FRC_EN];
  assign slow_rc_en          = clk_mode_r[`CBC_BIT_SRC_EN];
  assign crystal_osc_en      = xtal_r[`CBC_BIT_XTAL_EN];
  assign fast_rc_trim        = trim_r;
  assign sys_clk_sel         = sel_r;
  assign wdt_en              = wdt_r;
  assign port_a_pin_five_out = pa5_out_r;

endmodule

// *** cbc_clock_boot_control_tb.sv ***
// Purpose: Self-checking bench for the clock and boot control block
// Assumes: Normal boot count shortened to 20 slow RC ticks
// Notes:   Slow RC pin is driven only while a boot is counting
`timescale 1ns/1ps
`include "cbc_map.svh"

module cbc_clock_boot_control_tb;
  localparam int NORM_CYC = 20;
  // Design ports and bench state
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        slow_rc_pin, fast_boot_strap, core_rst_n, fast_rc_en, slow_rc_en;
  logic        crystal_osc_en, wdt_en, port_a_pin_five_out;
  logic [2:0]  calib_opt_strap, sys_clk_sel;
  logic [10:0] pc_start_addr, pc_irq_addr;
  logic [7:0]  fast_rc_trim;
  int          mismatches, comparisons;
  logic [7:0]  mode_tab [8] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hE4, 8'hF4, 8'hF4};

  cbc_clock_boot_control #(.BOOT_NORMAL_CYC(12'd20)) i_cbc_clock_boot_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .slow_rc_pin(slow_rc_pin), .fast_boot_strap(fast_boot_strap),
    .calib_opt_strap(calib_opt_strap), .core_rst_n(core_rst_n),
    .pc_start_addr(pc_start_addr), .pc_irq_addr(pc_irq_addr), .fast_rc_en(fast_rc_en),
    .slow_rc_en(slow_rc_en), .crystal_osc_en(crystal_osc_en), .fast_rc_trim(fast_rc_trim),
    .sys_clk_sel(sys_clk_sel), .wdt_en(wdt_en), .port_a_pin_five_out(port_a_pin_five_out)
  );

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; only the watchdog ends the wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("apb_wait", n, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One slow RC period of eight pclk cycles
  task automatic tick();
    slow_rc_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    slow_rc_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic do_reset(input logic fast, input logic [2:0] calib);
    presetn <= 1'b0;
    fast_boot_strap <= fast;
    calib_opt_strap <= calib;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // Boot; a software write opposite to the boot state must be overridden
  task automatic boot(input logic fast, input logic [2:0] calib);
    logic [2:0] sel;
    do_reset(fast, calib);
    apb(1'b1, `CBC_OFS_SYS_CTRL, (calib < 3'd5) ? 32'h3 : 32'h2);
    repeat ((fast ? 45 : NORM_CYC) - 1) tick();
    chk("held", core_rst_n, 1'b0);
    tick();
    chk("release", core_rst_n, 1'b1);
    sel = (calib < 3'd5) ? calib : ((calib == 3'd5 || !fast) ? 3'd6 : 3'd5);
    chk("sel", sys_clk_sel, sel);
    chk("fast_en", fast_rc_en, calib != 3'd5);
    chk("slow_en", slow_rc_en, 1'b1);
    chk("wdt", wdt_en, calib >= 3'd5);
    chk("pin", port_a_pin_five_out, 1'b0);
    apb(1'b0, `CBC_OFS_CLK_MODE, 32'h0);
    chk("mode", rd, {24'h0, mode_tab[calib]});
    apb(1'b0, `CBC_OFS_STATUS, 32'h0);
    chk("status", rd, {24'h0, calib, sel, fast, 1'b1});
  endtask

  // Reset in mid-count; the ticks counted so far must be dropped
  task automatic mid_reset();
    do_reset(1'b1, 3'd0);
    repeat (30) tick();
    chk("mid_held", core_rst_n, 1'b0);
    apb(1'b0, `CBC_OFS_BOOT_COUNT, 32'h0);
    chk("mid_count", rd, 32'h1E);
    do_reset(1'b1, 3'd0);
    apb(1'b0, `CBC_OFS_BOOT_COUNT, 32'h0);
    chk("count_clr", rd, 32'h0);
  endtask

  // Mode codes, enables, crystal, trim range, stack pointer, unmapped place
  task automatic regs();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `CBC_OFS_CLK_MODE, {24'h0, mode_tab[i]});
      @(posedge pclk);
      chk("sel_sw", sys_clk_sel, (i == 5) ? 3'd6 : i[2:0]);
      chk("frc_sw", fast_rc_en, mode_tab[i][4]);
      chk("src_sw", slow_rc_en, mode_tab[i][2]);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `CBC_OFS_XTAL_CTRL, i ? 32'h80 : 32'h7F);
      apb(1'b1, `CBC_OFS_FRC_TRIM, i ? 32'hFF : 32'h0);
      // Trim lands on the edge the transfer ends; look one edge later
      @(posedge pclk);
      chk("xtal", crystal_osc_en, i[0]);
      chk("trim", fast_rc_trim, i ? 8'hFF : 8'h00);
    end
    apb(1'b1, `CBC_OFS_STACK_PTR, 32'h7F);
    apb(1'b0, `CBC_OFS_STACK_PTR, 32'h0);
    chk("stack", rd, 32'h7F);
    apb(1'b0, 12'h030, 32'h0);
    chk("err", err, 1'b1);
    chk("err_data", rd, 32'h0);
  endtask

  // Byte, bit and indirect access reaching the top byte
  task automatic mem();
    apb(1'b1, `CBC_OFS_MEM_PTR, 32'h7F);
    apb(1'b1, `CBC_OFS_MEM_DATA, 32'h11);
    apb(1'b1, `CBC_OFS_MEM_PTR, 32'h5);
    apb(1'b1, `CBC_OFS_MEM_DATA, 32'h7F);
    apb(1'b1, `CBC_OFS_MEM_BIT, 32'hF);
    apb(1'b0, `CBC_OFS_MEM_DATA, 32'h0);
    chk("bit_set", rd, 32'hFF);
    apb(1'b0, `CBC_OFS_MEM_BIT, 32'h0);
    chk("bit_rd", rd, 32'hF);
    apb(1'b0, `CBC_OFS_MEM_IND, 32'h0);
    chk("indirect", rd, 32'h11);
    apb(1'b1, `CBC_OFS_MEM_BIT, 32'h0);
    apb(1'b0, `CBC_OFS_MEM_DATA, 32'h0);
    chk("bit_clr", rd, 32'hFE);
  endtask

  // Program word classes at every boundary of the map
  task automatic pmap();
    logic [10:0] adr [9] = '{11'h000, 11'h001, 11'h002, 11'h00F, 11'h010, 11'h011,
                             11'h7E7, 11'h7E8, 11'h7FF};
    logic [2:0]  cls;
    foreach (adr[i]) begin
      cls = (adr[i] == 11'h001) ? 3'd1 : (adr[i] == 11'h010) ? 3'd3 :
            (adr[i] == 11'h000 || adr[i] >= 11'h7E8) ? 3'd0 : 3'd2;
      apb(1'b1, `CBC_OFS_PMAP_CHECK, {21'h0, adr[i]});
      apb(1'b0, `CBC_OFS_PMAP_CHECK, 32'h0);
      chk("pmap", rd, {13'h0, cls, 5'h0, adr[i]});
    end
  endtask

  // Main sequence; a reset in mid-count comes first
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow_rc_pin = 1'b0;
    fast_boot_strap = 1'b1;
    calib_opt_strap = 3'd0;
    mismatches = 0;
    comparisons = 0;
    @(posedge pclk);
    mid_reset();
    for (int c = 0; c < 8; c++) boot(1'b1, c[2:0]);
    boot(1'b0, 3'd6);
    boot(1'b0, 3'd5);
    regs();
    mem();
    pmap();
    finish_test();
  end

  // Watchdog, well beyond the expected run
  initial begin
    #60000;
    mismatches++;
    finish_test();
  end
endmodule

// *** cbc_map.svh ***
// Purpose: Constants for the clock and boot control block: offsets, fields, resets, counts
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Included by the design, the checker and the bench; definitions only
//
// How it works
// - Core starts fetching at word 0x001; word 0x000 stays system use.
// - Taken interrupts vector execution to program word 0x10.
// - Program memory 2K x 14; top 24 words 0x7E8-0x7FF are system data.
// - User code lives at 0x002-0x00F and 0x011-0x7E7; 0x010 is the vector.
// - Power-on reset holds the whole device until the boot delay ends; here only core_rst_n is held, APB and registers run.
// - Boot delay is 45 slow RC cycles for fast boot, 3000 for normal.
// - Data memory allows whole-byte and single-bit reads and writes.
// - Stack lives in data memory, located by a software-set stack pointer.
// - Any data byte can point indirectly; all 128 bytes are reachable.
// - Crystal enable is bit 7 of its control; fast/slow RC use bits 4/2.
// - After boot both fast and slow internal RC oscillators run, except in the slow RC option, where fast RC is off.
// - A trim register adjusts fast RC frequency; usual target is 16MHz.
// - Trim range must reach any fast RC target from 14 to 18 MHz.
// - Clock mode 34h gives fast RC/2, 14h /4, 3Ch /8.
// - Clock mode 1Ch gives /16, 7Ch /32, E4h selects slow RC undivided.
// - Divided fast RC option: fast RC on, watchdog off, slow on, pin input.
// - Slow RC option: mode E4h, fast RC off, watchdog on, slow RC on.
// - Calibration off: mode keeps reset, watchdog on, clock slow or fast/64.
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH

// Register byte offsets
`define CBC_OFS_CLK_MODE    12'h000
`define CBC_OFS_XTAL_CTRL   12'h004
`define CBC_OFS_FRC_TRIM    12'h008
`define CBC_OFS_SYS_CTRL    12'h00C
`define CBC_OFS_STATUS      12'h010
`define CBC_OFS_BOOT_COUNT  12'h014
`define CBC_OFS_STACK_PTR   12'h018
`define CBC_OFS_PMAP_CHECK  12'h01C
`define CBC_OFS_MEM_PTR     12'h020
`define CBC_OFS_MEM_DATA    12'h024
`define CBC_OFS_MEM_BIT     12'h028
`define CBC_OFS_MEM_IND     12'h02C

// Field positions
`define CBC_BIT_XTAL_EN     7
`define CBC_BIT_FRC_EN      4
`define CBC_BIT_SRC_EN      2
`define CBC_BIT_WDT_EN      0
`define CBC_BIT_PA5_OUT     1
`define CBC_BIT_MEM_VAL     3

// Clock mode encodings
`define CBC_CLKMD_FRC2      8'h34
`define CBC_CLKMD_FRC4      8'h14
`define CBC_CLKMD_FRC8      8'h3C
`define CBC_CLKMD_FRC16     8'h1C
`define CBC_CLKMD_FRC32     8'h7C
`define CBC_CLKMD_SLOW      8'hE4

// Reset values
`define CBC_RST_CLK_MODE    8'hF4
`define CBC_RST_FRC_TRIM    8'h80
`define CBC_RST_XTAL_CTRL   8'h00

// Boot delay in slow RC cycles; strap wait in pclk cycles
`define CBC_BOOT_FAST       12'd45
`define CBC_BOOT_NORMAL     12'd3000
`define CBC_STRAP_WAIT      2'd2

// Program memory map, word addresses
`define CBC_PM_SYS_LOW      11'h000
`define CBC_PM_ENTRY        11'h001
`define CBC_PM_VECTOR       11'h010
`define CBC_PM_USER_TOP     11'h7E7
`define CBC_PM_SYS_HIGH     11'h7E8

`endif

// *** cbc_pkg.sv ***
// Purpose: Types shared by the clock and boot control block
// Assumes: Constants live in cbc_map.svh
// Notes:   No imports; users write cbc_pkg::name
package cbc_pkg;

  // System clock source selection
  typedef enum logic [2:0] {
    CBC_SEL_FRC2  = 3'b000,
    CBC_SEL_FRC4  = 3'b001,
    CBC_SEL_FRC8  = 3'b010,
    CBC_SEL_FRC16 = 3'b011,
    CBC_SEL_FRC32 = 3'b100,
    CBC_SEL_FRC64 = 3'b101,
    CBC_SEL_SLOW  = 3'b110
  } cbc_clk_sel_t;

  // Boot sequencer states
  typedef enum logic [1:0] {
    CBC_ST_STRAP = 2'b00,
    CBC_ST_COUNT = 2'b01,
    CBC_ST_APPLY = 2'b10,
    CBC_ST_RUN   = 2'b11
  } cbc_state_t;

  // Program word classes
  typedef enum logic [2:0] {
    CBC_PM_SYSTEM = 3'b000,
    CBC_PM_START  = 3'b001,
    CBC_PM_USER   = 3'b010,
    CBC_PM_IRQ    = 3'b011
  } cbc_pm_class_t;

endpackage
